// ---- logic/comparator_regs.sv ----
// Low-power comparator register bank: interrupt enables, result, enable and input select
`default_nettype none
`include "comparator_defines.svh"
module comparator_regs (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic                      clk_en,
  input  wire logic                      awvalid,
  output logic                           awready,
  input  wire logic [`ADDR_W-1:0]        awaddr,
  input  wire logic                      wvalid,
  output logic                           wready,
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  output logic                           bvalid,
  input  wire logic                      bready,
  output logic [1:0]                     bresp,
  input  wire logic                      arvalid,
  output logic                           arready,
  input  wire logic [`ADDR_W-1:0]        araddr,
  output logic                           rvalid,
  input  wire logic                      rready,
  output logic [31:0]                    rdata,
  output logic [1:0]                     rresp,
  input  wire logic                      compare_raw,
  input  wire logic                      ready_raw,
  input  wire logic                      sample_task,
  output logic                           comparator_enable,
  output logic [`CHANNEL_WIDTH-1:0]      channel_select,
  output comparator_pkg::event_vec_t     event_flags,
  output logic                           irq
);
  comparator_pkg::regs_state_t q;
  comparator_pkg::regs_state_t next_q;
  comparator_pkg::event_vec_t  hw_event;
  comparator_pkg::event_vec_t  clear_mask;
  logic                        cross_ok;

  reg_access_if acc ();

  axi_lite_slave u_bus (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clk_en  (clk_en),
    .awvalid (awvalid),
    .awready (awready),
    .awaddr  (awaddr),
    .wvalid  (wvalid),
    .wready  (wready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .bvalid  (bvalid),
    .bready  (bready),
    .bresp   (bresp),
    .arvalid (arvalid),
    .arready (arready),
    .araddr  (araddr),
    .rvalid  (rvalid),
    .rready  (rready),
    .rdata   (rdata),
    .rresp   (rresp),
    .acc     (acc.bus)
  );

  function automatic logic lane0_write(input logic               en,
                                       input logic [3:0]         strb,
                                       input logic [`ADDR_W-1:0] addr,
                                       input logic [`ADDR_W-1:0] off);
    lane0_write = en && strb[0] && addr == off;
  endfunction

  function automatic logic is_mapped(input logic [`ADDR_W-1:0] addr);
    case (addr)
      `OFF_IRQ_ENABLE_SET, `OFF_IRQ_ENABLE_CLEAR, `OFF_COMPARE_OUTCOME,
      `OFF_COMPARATOR_ON, `OFF_INPUT_CHANNEL_SELECT, `OFF_EVENT_STATUS,
      `OFF_EVENT_CLEAR: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  assign comparator_enable = q.enable;
  assign channel_select    = q.channel;
  assign event_flags       = q.status;
  assign irq               = q.irq;

  // Crossings count only after ready has stood a cycle, so the settling edge is not a crossing
  assign cross_ok = q.enable && q.rdy_sync && q.rdy_last;

  always_comb begin
    hw_event                 = '0;
    hw_event[`BIT_SETTLED]   = q.enable && q.rdy_sync && !q.rdy_last;
    hw_event[`BIT_FALL]      = cross_ok && q.cmp_last && !q.cmp_sync;
    hw_event[`BIT_RISE]      = cross_ok && !q.cmp_last && q.cmp_sync;
    hw_event[`BIT_CROSS]     = cross_ok && (q.cmp_last != q.cmp_sync);
    clear_mask = '0;
    if (lane0_write(acc.wr_en, acc.wr_strb, acc.wr_addr, `OFF_EVENT_CLEAR)) begin
      clear_mask = acc.wr_data[`EVENT_COUNT-1:0];
    end
  end

  always_comb begin
    next_q          = q;
    next_q.cmp_meta = compare_raw;
    next_q.cmp_sync = q.cmp_meta;
    next_q.cmp_last = q.cmp_sync;
    next_q.rdy_meta = ready_raw;
    next_q.rdy_sync = q.rdy_meta;
    next_q.rdy_last = q.rdy_sync;
    if (lane0_write(acc.wr_en, acc.wr_strb, acc.wr_addr, `OFF_IRQ_ENABLE_SET)) begin
      next_q.irq_en = q.irq_en | acc.wr_data[`EVENT_COUNT-1:0];
    end
    if (lane0_write(acc.wr_en, acc.wr_strb, acc.wr_addr, `OFF_IRQ_ENABLE_CLEAR)) begin
      next_q.irq_en = q.irq_en & ~acc.wr_data[`EVENT_COUNT-1:0];
    end
    if (lane0_write(acc.wr_en, acc.wr_strb, acc.wr_addr, `OFF_COMPARATOR_ON)) begin
      next_q.enable = acc.wr_data[0];
    end
    if (lane0_write(acc.wr_en, acc.wr_strb, acc.wr_addr, `OFF_INPUT_CHANNEL_SELECT)) begin
      next_q.channel = acc.wr_data[`CHANNEL_WIDTH-1:0];
    end
    // A disabled comparator has no decision to offer, so a sample then keeps the old result
    if (sample_task && q.enable) begin
      next_q.outcome = q.cmp_sync;
    end
    // Set wins over clear so an event landing on the clear write is not lost
    next_q.status = (q.status & ~clear_mask) | hw_event;
    next_q.irq    = |(next_q.status & next_q.irq_en);
  end

  always_comb begin
    acc.rd_data = 32'h0000_0000;
    acc.rd_err  = !is_mapped(acc.rd_addr);
    acc.wr_err  = !is_mapped(acc.wr_addr);
    case (acc.rd_addr)
      `OFF_IRQ_ENABLE_SET, `OFF_IRQ_ENABLE_CLEAR: begin
        acc.rd_data[`EVENT_COUNT-1:0] = q.irq_en;
      end
      `OFF_COMPARE_OUTCOME:      acc.rd_data[0] = q.outcome;
      `OFF_COMPARATOR_ON:        acc.rd_data[0] = q.enable;
      `OFF_INPUT_CHANNEL_SELECT: acc.rd_data[`CHANNEL_WIDTH-1:0] = q.channel;
      `OFF_EVENT_STATUS:         acc.rd_data[`EVENT_COUNT-1:0] = q.status;
      default:                   acc.rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= `STATE_RESET;
    end else if (clk_en) begin
      q <= next_q;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence set_write_s;
    lane0_write(acc.wr_en, acc.wr_strb, acc.wr_addr, `OFF_IRQ_ENABLE_SET);
  endsequence

  enable_set_a: assert property (set_write_s |=>
    (q.irq_en & $past(acc.wr_data[3:0])) == $past(acc.wr_data[3:0]))
    else $error("enable set write did not turn enables on");

  enable_clear_a: assert property (
    lane0_write(acc.wr_en, acc.wr_strb, acc.wr_addr, `OFF_IRQ_ENABLE_CLEAR)
    |=> (q.irq_en & $past(acc.wr_data[3:0])) == 4'h0)
    else $error("enable clear write left an enable on");

  result_read_a: assert property (
    (arvalid && arready && araddr == `OFF_COMPARE_OUTCOME) ##1 clk_en
    |=> rdata == {31'h0000_0000, $past(q.outcome)} && rresp == `RESP_OKAY)
    else $error("result read does not return the held decision");

  sample_capture_a: assert property (
    sample_task && q.enable && clk_en |=> q.outcome == $past(q.cmp_sync))
    else $error("sample task did not capture the comparator decision");

  result_hold_a: assert property (
    !(sample_task && q.enable) && clk_en |=> $stable(q.outcome))
    else $error("result changed without a sample task");

  enable_write_a: assert property (
    lane0_write(acc.wr_en, acc.wr_strb, acc.wr_addr, `OFF_COMPARATOR_ON)
    |=> comparator_enable == $past(acc.wr_data[0]))
    else $error("peripheral enable did not follow the write");

  channel_write_a: assert property (
    lane0_write(acc.wr_en, acc.wr_strb, acc.wr_addr, `OFF_INPUT_CHANNEL_SELECT)
    |=> channel_select == $past(acc.wr_data[2:0]))
    else $error("input select did not follow the write");

  settled_flag_a: assert property (
    (clk_en && q.enable && !q.rdy_sync && q.rdy_meta) ##1 clk_en
    |=> event_flags[`BIT_SETTLED])
    else $error("settled flag missing after comparator became ready");

  irq_level_a: assert property (
    irq == |(event_flags & q.irq_en))
    else $error("interrupt level disagrees with flags and enables");

  set_wins_a: assert property (
    clk_en && |(hw_event & clear_mask) |=> |(event_flags & $past(hw_event & clear_mask)))
    else $error("event lost to a clear in the same cycle");

  sync_delay_a: assert property (
    (clk_en && aresetn) ##1 (clk_en && aresetn) |=> q.cmp_sync == $past(compare_raw, 2))
    else $error("compare input not passed through two flops");

  settled_c: cover property (q.enable ##1 event_flags[`BIT_SETTLED]);
  rise_c:    cover property (clk_en && hw_event[`BIT_RISE]);
  fall_c:    cover property (clk_en && hw_event[`BIT_FALL]);
  sample_c:  cover property (sample_task && q.enable && q.cmp_sync);
  irq_c:     cover property (!irq ##1 irq);
endmodule // comparator_regs
`default_nettype wire

// ---- logic/comparator_defines.svh ----
// Offsets, field positions, reset values and codes of the comparator register bank
`ifndef COMPARATOR_DEFINES_SVH
`define COMPARATOR_DEFINES_SVH
`define ADDR_W                   12
`define OFF_IRQ_ENABLE_SET       12'h304
`define OFF_IRQ_ENABLE_CLEAR     12'h308
`define OFF_COMPARE_OUTCOME      12'h400
`define OFF_COMPARATOR_ON        12'h500
`define OFF_INPUT_CHANNEL_SELECT 12'h504
`define OFF_EVENT_STATUS         12'h600
`define OFF_EVENT_CLEAR          12'h604
`define BIT_SETTLED              0
`define BIT_FALL                 1
`define BIT_RISE                 2
`define BIT_CROSS                3
`define EVENT_COUNT              4
`define CHANNEL_WIDTH            3
`define STATE_RESET              '0
`define RESP_OKAY                2'h0
`define RESP_SLVERR              2'h2
`endif

// ---- logic/comparator_pkg.sv ----
// Types shared by the comparator register bank and its bus slave
`default_nettype none
`include "comparator_defines.svh"
package comparator_pkg;
  typedef enum logic [1:0] {WS_IDLE = 2'h0, WS_EXEC = 2'h1, WS_RESP = 2'h3} wr_state_t;
  typedef enum logic [1:0] {RS_IDLE = 2'h0, RS_EXEC = 2'h1, RS_RESP = 2'h3} rd_state_t;
  typedef logic [`EVENT_COUNT-1:0] event_vec_t;
  typedef struct packed {
    wr_state_t              ws;
    rd_state_t              rs;
    logic                   aw_got;
    logic                   w_got;
    logic [`ADDR_W-1:0]     awaddr;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic [`ADDR_W-1:0]     araddr;
    logic [31:0]            rdata;
    logic                   bresp_err;
    logic                   rresp_err;
  } bus_state_t;
  typedef struct packed {
    logic                      enable;
    logic [`CHANNEL_WIDTH-1:0] channel;
    event_vec_t                irq_en;
    event_vec_t                status;
    logic                      outcome;
    logic                      irq;
    logic                      cmp_meta;
    logic                      cmp_sync;
    logic                      cmp_last;
    logic                      rdy_meta;
    logic                      rdy_sync;
    logic                      rdy_last;
  } regs_state_t;
endpackage
`default_nettype wire

// ---- logic/reg_access_if.sv ----
// Register access strobes between the bus slave and the register bank
`default_nettype none
`include "comparator_defines.svh"
interface reg_access_if;
  logic               wr_en;
  logic [`ADDR_W-1:0] wr_addr;
  logic [31:0]        wr_data;
  logic [3:0]         wr_strb;
  logic               wr_err;
  logic [`ADDR_W-1:0] rd_addr;
  logic [31:0]        rd_data;
  logic               rd_err;
  modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                input  wr_err, rd_data, rd_err);
  modport regs (input  wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                output wr_err, rd_data, rd_err);
endinterface
`default_nettype wire

// ---- logic/axi_lite_slave.sv ----
// AXI4-Lite slave that turns bus transfers into register access strobes
`default_nettype none
`include "comparator_defines.svh"
module axi_lite_slave (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               clk_en,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [`ADDR_W-1:0] awaddr,
  input  wire logic               wvalid,
  output logic                    wready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  output logic                    bvalid,
  input  wire logic               bready,
  output logic [1:0]              bresp,
  input  wire logic               arvalid,
  output logic                    arready,
  input  wire logic [`ADDR_W-1:0] araddr,
  output logic                    rvalid,
  input  wire logic               rready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  reg_access_if.bus               acc
);
  comparator_pkg::bus_state_t q;
  comparator_pkg::bus_state_t next_q;

  // Handshakes follow the clock enable so no transfer is seen while state is frozen
  assign awready     = clk_en && q.ws == comparator_pkg::WS_IDLE && !q.aw_got;
  assign wready      = clk_en && q.ws == comparator_pkg::WS_IDLE && !q.w_got;
  assign bvalid      = clk_en && q.ws == comparator_pkg::WS_RESP;
  assign bresp       = q.bresp_err ? `RESP_SLVERR : `RESP_OKAY;
  assign arready     = clk_en && q.rs == comparator_pkg::RS_IDLE;
  assign rvalid      = clk_en && q.rs == comparator_pkg::RS_RESP;
  assign rdata       = q.rdata;
  assign rresp       = q.rresp_err ? `RESP_SLVERR : `RESP_OKAY;
  assign acc.wr_en   = clk_en && q.ws == comparator_pkg::WS_EXEC;
  assign acc.wr_addr = q.awaddr;
  assign acc.wr_data = q.wdata;
  assign acc.wr_strb = q.wstrb;
  assign acc.rd_addr = q.araddr;

  always_comb begin
    next_q = q;
    case (q.ws)
      comparator_pkg::WS_IDLE: begin
        if (awvalid && awready) begin
          next_q.aw_got = 1'b1;
          next_q.awaddr = awaddr;
        end
        if (wvalid && wready) begin
          next_q.w_got = 1'b1;
          next_q.wdata = wdata;
          next_q.wstrb = wstrb;
        end
        if (next_q.aw_got && next_q.w_got) next_q.ws = comparator_pkg::WS_EXEC;
      end
      comparator_pkg::WS_EXEC: begin
        next_q.bresp_err = acc.wr_err;
        next_q.ws        = comparator_pkg::WS_RESP;
      end
      comparator_pkg::WS_RESP: begin
        if (bready) begin
          next_q.ws     = comparator_pkg::WS_IDLE;
          next_q.aw_got = 1'b0;
          next_q.w_got  = 1'b0;
        end
      end
      default: next_q.ws = comparator_pkg::WS_IDLE;
    endcase
    case (q.rs)
      comparator_pkg::RS_IDLE: begin
        if (arvalid) begin
          next_q.araddr = araddr;
          next_q.rs     = comparator_pkg::RS_EXEC;
        end
      end
      comparator_pkg::RS_EXEC: begin
        next_q.rdata     = acc.rd_data;
        next_q.rresp_err = acc.rd_err;
        next_q.rs        = comparator_pkg::RS_RESP;
      end
      comparator_pkg::RS_RESP: if (rready) next_q.rs = comparator_pkg::RS_IDLE;
      default: next_q.rs = comparator_pkg::RS_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= `STATE_RESET;
    end else if (clk_en) begin
      q <= next_q;
    end
  end
endmodule // axi_lite_slave
`default_nettype wire

// ---- test/comparator_regs_bench.sv ----
// Self-checking bench for the comparator register bank over AXI4-Lite
`default_nettype none
`include "comparator_defines.svh"
module comparator_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                       aclk;
  logic                       aresetn;
  logic                       clk_en;
  logic                       awvalid;
  logic                       awready;
  logic [`ADDR_W-1:0]         awaddr;
  logic                       wvalid;
  logic                       wready;
  logic [31:0]                wdata;
  logic [3:0]                 wstrb;
  logic                       bvalid;
  logic                       bready;
  logic [1:0]                 bresp;
  logic                       arvalid;
  logic                       arready;
  logic [`ADDR_W-1:0]         araddr;
  logic                       rvalid;
  logic                       rready;
  logic [31:0]                rdata;
  logic [1:0]                 rresp;
  logic                       compare_raw;
  logic                       ready_raw;
  logic                       sample_task;
  logic                       comparator_enable;
  logic [`CHANNEL_WIDTH-1:0]  channel_select;
  comparator_pkg::event_vec_t event_flags;
  logic                       irq;
  int                         n_fail;
  int                         n_compared;

  comparator_regs uut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .compare_raw(compare_raw), .ready_raw(ready_raw), .sample_task(sample_task),
    .comparator_enable(comparator_enable), .channel_select(channel_select),
    .event_flags(event_flags), .irq(irq));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Ready is combinational on held inputs, so its negedge value is the edge value
  task automatic wr(input logic [`ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    int   n;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok) && n < 200) begin
      @(negedge aclk);
      aw_ok = aw_ok | awready;
      w_ok = w_ok | wready;
      @(posedge aclk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
      n++;
    end
    do begin
      @(negedge aclk);
      n++;
    end while (!bvalid && n < 200);
    cmp(32'(bresp), 32'(er), "write response");
    // bready stays high between writes so a back-to-back call never drives it twice in one step
    @(posedge aclk);
  endtask

  task automatic rd(input logic [`ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      n++;
    end while (!arready && n < 200);
    @(posedge aclk);
    arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      n++;
    end while (!rvalid && n < 200);
    cmp(rdata, ed, "read data");
    cmp(32'(rresp), 32'(er), "read response");
    @(posedge aclk);
  endtask

  // Compares an output that the caller samples away from the launching edge; it waits on no edge itself
  task automatic peek(input logic [31:0] got_sel, input logic [31:0] exp, input string what);
    cmp(got_sel, exp, what);
  endtask

  task automatic pause(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    #800000;
    n_fail++;
    close_out();
  end

  logic [`ADDR_W-1:0] reg_offs [5];
  initial begin
    reg_offs = '{`OFF_IRQ_ENABLE_SET, `OFF_IRQ_ENABLE_CLEAR, `OFF_COMPARE_OUTCOME,
                 `OFF_COMPARATOR_ON, `OFF_INPUT_CHANNEL_SELECT};
    n_fail = 0;
    n_compared = 0;
    aresetn = 1'b0;
    clk_en = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h00000000;
    wstrb = 4'h0;
    {compare_raw, ready_raw, sample_task} = 3'h0;
    pause(4);
    aresetn <= 1'b1;
    pause(1);
    foreach (reg_offs[i]) rd(reg_offs[i], 32'h00000000, `RESP_OKAY);
    $display("test reset values done");
    wr(`OFF_IRQ_ENABLE_SET, 32'h00000005, `RESP_OKAY);
    rd(`OFF_IRQ_ENABLE_SET, 32'h00000005, `RESP_OKAY);
    wr(`OFF_IRQ_ENABLE_SET, 32'h0000000A, `RESP_OKAY);
    rd(`OFF_IRQ_ENABLE_CLEAR, 32'h0000000F, `RESP_OKAY);
    wr(`OFF_IRQ_ENABLE_CLEAR, 32'h00000003, `RESP_OKAY);
    rd(`OFF_IRQ_ENABLE_SET, 32'h0000000C, `RESP_OKAY);
    wr(`OFF_IRQ_ENABLE_CLEAR, 32'h0000000C, `RESP_OKAY);
    rd(`OFF_IRQ_ENABLE_CLEAR, 32'h00000000, `RESP_OKAY);
    wr(12'h0FC, 32'h00000001, `RESP_SLVERR);
    rd(12'h0FC, 32'h00000000, `RESP_SLVERR);
    $display("test interrupt enables done");
    for (int c = 0; c < 8; c++) begin
      wr(`OFF_INPUT_CHANNEL_SELECT, 32'(c), `RESP_OKAY);
      rd(`OFF_INPUT_CHANNEL_SELECT, 32'(c), `RESP_OKAY);
      @(negedge aclk);
      peek(32'(channel_select), 32'(c), "channel select");
      @(posedge aclk);
    end
    $display("test input select done");
    wr(`OFF_COMPARATOR_ON, 32'h00000001, `RESP_OKAY);
    rd(`OFF_COMPARATOR_ON, 32'h00000001, `RESP_OKAY);
    ready_raw <= 1'b1;
    pause(6);
    @(negedge aclk);
    peek(32'(event_flags), 32'h00000001, "settled flag");
    peek(32'(irq), 32'h00000000, "irq masked");
    peek(32'(comparator_enable), 32'h00000001, "enable out");
    @(posedge aclk);
    wr(`OFF_IRQ_ENABLE_SET, 32'h00000001, `RESP_OKAY);
    @(negedge aclk);
    peek(32'(irq), 32'h00000001, "irq on settled");
    @(posedge aclk);
    wr(`OFF_EVENT_CLEAR, 32'h0000000F, `RESP_OKAY);
    @(negedge aclk);
    peek(32'(irq), 32'h00000000, "irq after flag clear");
    @(posedge aclk);
    $display("test settled event done");
    compare_raw <= 1'b1;
    pause(6);
    sample_task <= 1'b1;
    pause(1);
    sample_task <= 1'b0;
    rd(`OFF_COMPARE_OUTCOME, 32'h00000001, `RESP_OKAY);
    rd(`OFF_EVENT_STATUS, 32'h0000000C, `RESP_OKAY);
    compare_raw <= 1'b0;
    pause(6);
    rd(`OFF_COMPARE_OUTCOME, 32'h00000001, `RESP_OKAY);
    wr(`OFF_IRQ_ENABLE_SET, 32'h00000002, `RESP_OKAY);
    @(negedge aclk);
    peek(32'(irq), 32'h00000001, "irq on fall");
    @(posedge aclk);
    wr(`OFF_IRQ_ENABLE_CLEAR, 32'h00000002, `RESP_OKAY);
    @(negedge aclk);
    peek(32'(irq), 32'h00000000, "irq masked fall");
    @(posedge aclk);
    sample_task <= 1'b1;
    pause(1);
    sample_task <= 1'b0;
    wr(`OFF_COMPARE_OUTCOME, 32'h00000001, `RESP_OKAY);
    rd(`OFF_COMPARE_OUTCOME, 32'h00000000, `RESP_OKAY);
    wr(`OFF_COMPARATOR_ON, 32'h00000000, `RESP_OKAY);
    compare_raw <= 1'b1;
    pause(6);
    sample_task <= 1'b1;
    pause(1);
    sample_task <= 1'b0;
    rd(`OFF_COMPARE_OUTCOME, 32'h00000000, `RESP_OKAY);
    @(negedge aclk);
    peek(32'(comparator_enable), 32'h00000000, "enable off");
    @(posedge aclk);
    $display("test compare outcome done");
    clk_en <= 1'b0;
    pause(2);
    @(negedge aclk);
    peek(32'({awready, wready, arready, bvalid, rvalid}), 32'h00000000, "frozen handshakes");
    peek(32'(channel_select), 32'h00000007, "frozen select");
    @(posedge aclk);
    clk_en <= 1'b1;
    aresetn <= 1'b0;
    pause(2);
    aresetn <= 1'b1;
    pause(1);
    rd(`OFF_IRQ_ENABLE_SET, 32'h00000000, `RESP_OKAY);
    rd(`OFF_COMPARATOR_ON, 32'h00000000, `RESP_OKAY);
    rd(`OFF_COMPARE_OUTCOME, 32'h00000000, `RESP_OKAY);
    rd(`OFF_INPUT_CHANNEL_SELECT, 32'h00000000, `RESP_OKAY);
    $display("test freeze and mid-run reset done");
    close_out();
  end
endmodule // comparator_regs_bench
`default_nettype wire
